// file: design/psr_pkg.sv
// Purpose: Shared constants for the live status and interrupt enable block
// Assumes: APB byte address is four times the register index
// Notes: Status input vector positions are shared with the top module
package psr_pkg;
  // Register indices, byte address is index times four
  localparam logic [7:0] IDX_BASIC = 8'h01;
  localparam logic [7:0] IDX_STAT = 8'h11;
  localparam logic [7:0] IDX_IEN = 8'h12;
  localparam logic [7:0] IDX_CHG = 8'h13;
  localparam logic [7:0] IDX_FLT = 8'h1F;
  // Reset values and writable bits
  localparam logic [15:0] STAT_RST = 16'h0000;
  localparam logic [7:0] IEN_RST = 8'h00;
  localparam logic [7:0] IEN_WMASK = 8'hF3;
  // Positions in the synchronised status vector
  localparam int ST_SPD = 0;
  localparam int ST_TX = 1;
  localparam int ST_RX = 2;
  localparam int ST_COL = 3;
  localparam int ST_LNK = 4;
  localparam int ST_DUP = 5;
  localparam int ST_ANM = 6;
  localparam int ST_AND = 7;
  localparam int ST_POL = 8;
  localparam int ST_PAU = 9;
  localparam int ST_RF = 10;
  localparam int ST_JAB = 11;
  localparam int ST_PDF = 12;
  localparam int ST_W = 13;
  // Live status register fields
  localparam int B_SPD = 14;
  localparam int B_TX = 13;
  localparam int B_RX = 12;
  localparam int B_COL = 11;
  localparam int B_LNK = 10;
  localparam int B_DUP = 9;
  localparam int B_ANM = 8;
  localparam int B_AND = 7;
  localparam int B_POL = 5;
  localparam int B_PAU = 4;
  localparam int B_ERR = 3;
  // Interrupt enable fields
  localparam int E_AN = 7;
  localparam int E_SPD = 6;
  localparam int E_DUP = 5;
  localparam int E_LNK = 4;
  localparam int E_GEN = 1;
  localparam int E_TST = 0;
  // Status change fields
  localparam int C_AND = 7;
  localparam int C_SPD = 6;
  localparam int C_DUP = 5;
  localparam int C_LNK = 4;
  localparam int C_PEND = 2;
  // Basic status field
  localparam int BS_AND = 5;
endpackage : psr_pkg

// file: design/psr_regs.sv
// Purpose: Live status, interrupt enable and change registers over APB
// Assumes: Zero wait APB slave, 32 bit data, index times four addressing
// Notes: Read data is captured in the setup phase of each transfer
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Status bit 14 reads 1 in 100 Mbit twisted-pair mode.
// - Status bit 13 reads 1 while a packet is transmitted.
// - Status bit 12 reads 1 while a packet is received.
// - Status bit 11 reads 1 while a collision occurs.
// - Status bit 8 reads 1 when settings come from auto-negotiation.
// - Status bit 7 mirrors the negotiation complete bit of basic status.
// - Status bit 5 shows reversed polarity; meaningless at 100 Mbit.
// - Status bit 4 shows pause capability, zero by default.
// - Status bit 3 latches faults, clears when fault register is read.
// - Enable bit 7 lets negotiation complete raise an interrupt.
// - Enable bit 6 lets a speed change raise an interrupt.
// - Enable bit 5 lets a duplex change raise an interrupt.
// - Enable bit 4 lets a link change raise an interrupt.
// - Enable bit 1 is the global interrupt enable.
// - Enable bit 0 forces the interrupt pin low for test.
// - Change flags set on change, the negotiation flag on completion only; all clear when change register read.
// - Change register bit 2 reads 1 while an interrupt is pending.
module psr_regs (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Live state from the transceiver core
  input wire logic speed_100,
  input wire logic tx_active,
  input wire logic rx_active,
  input wire logic collision,
  input wire logic link_up,
  input wire logic full_duplex,
  input wire logic autoneg_mode,
  input wire logic autoneg_done,
  input wire logic polarity_rev,
  input wire logic pause_capable,
  input wire logic remote_fault,
  input wire logic jabber,
  input wire logic pd_fault,
  // Management interrupt
  output logic mgmt_irq_n
);
  logic [psr_pkg::ST_W-1:0] raw;
  logic [psr_pkg::ST_W-1:0] st;
  logic [7:0] ien;
  logic prev_spd;
  logic prev_dup;
  logic prev_lnk;
  logic prev_and;
  logic speed_changed_flag;
  logic duplex_changed_flag;
  logic link_changed_flag;
  logic an_done_flag;
  logic [2:0] flt;
  logic [3:0] clr_chg;
  logic [2:0] clr_flt;
  logic hit_q;
  logic [7:0] idx;
  logic hit;
  logic setup;
  logic access;
  logic [15:0] stat_word;
  logic [15:0] chg_word;
  logic [15:0] next_rdata;
  logic any_ev;
  logic rd_chg;
  logic rd_flt;

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisation
  assign raw = {pd_fault, jabber, remote_fault, pause_capable, polarity_rev,
                autoneg_done, autoneg_mode, full_duplex, link_up,
                collision, rx_active, tx_active, speed_100};

  psr_sync #(
    .WIDTH(psr_pkg::ST_W)
  ) u_psr_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din(raw),
    .dout(st)
  );

  ////////////////////////////////////////////////////////////////////////
  // Address decode
  assign idx = paddr[9:2];
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign hit = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0) &&
               ((idx == psr_pkg::IDX_BASIC) || (idx == psr_pkg::IDX_STAT) ||
                (idx == psr_pkg::IDX_IEN) || (idx == psr_pkg::IDX_CHG) ||
                (idx == psr_pkg::IDX_FLT));
  assign pready = 1'b1;
  assign pslverr = access & ~hit_q;
  assign rd_chg = access & ~pwrite & hit_q & (idx == psr_pkg::IDX_CHG);
  assign rd_flt = access & ~pwrite & hit_q & (idx == psr_pkg::IDX_FLT);

  ////////////////////////////////////////////////////////////////////////
  // Live status word
  always_comb begin
    stat_word = psr_pkg::STAT_RST;
    stat_word[psr_pkg::B_SPD] = st[psr_pkg::ST_SPD];
    stat_word[psr_pkg::B_TX] = st[psr_pkg::ST_TX];
    stat_word[psr_pkg::B_RX] = st[psr_pkg::ST_RX];
    stat_word[psr_pkg::B_COL] = st[psr_pkg::ST_COL];
    stat_word[psr_pkg::B_LNK] = st[psr_pkg::ST_LNK];
    stat_word[psr_pkg::B_DUP] = st[psr_pkg::ST_DUP];
    stat_word[psr_pkg::B_ANM] = st[psr_pkg::ST_ANM];
    stat_word[psr_pkg::B_AND] = st[psr_pkg::ST_AND];
    stat_word[psr_pkg::B_POL] = st[psr_pkg::ST_POL];
    stat_word[psr_pkg::B_PAU] = st[psr_pkg::ST_PAU];
    stat_word[psr_pkg::B_ERR] = |flt;
  end

  // Status change word
  always_comb begin
    chg_word = 16'h0000;
    chg_word[psr_pkg::C_AND] = st[psr_pkg::ST_AND];
    chg_word[psr_pkg::C_SPD] = speed_changed_flag;
    chg_word[psr_pkg::C_DUP] = duplex_changed_flag;
    chg_word[psr_pkg::C_LNK] = link_changed_flag;
    chg_word[psr_pkg::C_PEND] = ~mgmt_irq_n;
  end

  // Read mux
  always_comb begin
    next_rdata = 16'h0000;
    case (idx)
      psr_pkg::IDX_BASIC: begin
        next_rdata[psr_pkg::BS_AND] = st[psr_pkg::ST_AND];
      end
      psr_pkg::IDX_STAT: next_rdata = stat_word;
      psr_pkg::IDX_IEN: next_rdata = {8'h00, ien};
      psr_pkg::IDX_CHG: next_rdata = chg_word;
      psr_pkg::IDX_FLT: next_rdata = {13'h0000, flt};
      default: next_rdata = 16'h0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data and clear masks captured in setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      hit_q <= 1'b0;
      clr_chg <= 4'h0;
      clr_flt <= 3'h0;
    end else if (setup) begin
      prdata <= (hit && !pwrite) ? {16'h0000, next_rdata} : 32'h00000000;
      hit_q <= hit;
      clr_chg <= {an_done_flag, speed_changed_flag, duplex_changed_flag,
                  link_changed_flag};
      clr_flt <= flt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt enable register, reserved bits dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ien <= psr_pkg::IEN_RST;
    end else if (access && pwrite && hit_q && pstrb[0] &&
                 idx == psr_pkg::IDX_IEN) begin
      ien <= pwdata[7:0] & psr_pkg::IEN_WMASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Previous values for change detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_spd <= 1'b0;
      prev_dup <= 1'b0;
      prev_lnk <= 1'b0;
      prev_and <= 1'b0;
    end else begin
      prev_spd <= st[psr_pkg::ST_SPD];
      prev_dup <= st[psr_pkg::ST_DUP];
      prev_lnk <= st[psr_pkg::ST_LNK];
      prev_and <= st[psr_pkg::ST_AND];
    end
  end

  // Sticky change flags, a new change beats the read clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      speed_changed_flag <= 1'b0;
      duplex_changed_flag <= 1'b0;
      link_changed_flag <= 1'b0;
      an_done_flag <= 1'b0;
    end else begin
      speed_changed_flag <= (st[psr_pkg::ST_SPD] ^ prev_spd) |
        (speed_changed_flag & ~(rd_chg & clr_chg[2]));
      duplex_changed_flag <= (st[psr_pkg::ST_DUP] ^ prev_dup) |
        (duplex_changed_flag & ~(rd_chg & clr_chg[1]));
      link_changed_flag <= (st[psr_pkg::ST_LNK] ^ prev_lnk) |
        (link_changed_flag & ~(rd_chg & clr_chg[0]));
      an_done_flag <= (st[psr_pkg::ST_AND] & ~prev_and) |
        (an_done_flag & ~(rd_chg & clr_chg[3]));
    end
  end

  // Fault latches, cleared by reading the fault register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flt <= 3'h0;
    end else begin
      flt <= {st[psr_pkg::ST_PDF], st[psr_pkg::ST_JAB], st[psr_pkg::ST_RF]} |
             (flt & ~({3{rd_flt}} & clr_flt));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt pin
  assign any_ev = (ien[psr_pkg::E_AN] & an_done_flag) |
                  (ien[psr_pkg::E_SPD] & speed_changed_flag) |
                  (ien[psr_pkg::E_DUP] & duplex_changed_flag) |
                  (ien[psr_pkg::E_LNK] & link_changed_flag);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mgmt_irq_n <= 1'b1;
    end else begin
      mgmt_irq_n <= ~((ien[psr_pkg::E_GEN] & any_ev) |
                      ien[psr_pkg::E_TST]);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic rd_stat;
  assign rd_stat = access & ~pwrite & hit_q & (idx == psr_pkg::IDX_STAT);

  a_speed_bit: assert property (
    rd_stat |-> prdata[14] == $past(st[psr_pkg::ST_SPD]))
    else $error("speed bit wrong");
  a_tx_bit: assert property (
    rd_stat |-> prdata[13] == $past(st[psr_pkg::ST_TX]))
    else $error("transmit bit wrong");
  a_rx_bit: assert property (
    rd_stat |-> prdata[12] == $past(st[psr_pkg::ST_RX]))
    else $error("receive bit wrong");
  a_col_bit: assert property (
    rd_stat |-> prdata[11] == $past(st[psr_pkg::ST_COL]))
    else $error("collision bit wrong");
  a_anmode_bit: assert property (
    rd_stat |-> prdata[8] == $past(st[psr_pkg::ST_ANM]))
    else $error("negotiation mode bit wrong");
  a_andone_bit: assert property (
    rd_stat |-> prdata[7] == $past(st[psr_pkg::ST_AND]))
    else $error("negotiation complete bit wrong");
  a_pol_bit: assert property (
    rd_stat |-> prdata[5] == $past(st[psr_pkg::ST_POL]))
    else $error("polarity bit wrong");
  a_pause_bit: assert property (
    rd_stat |-> prdata[4] == $past(st[psr_pkg::ST_PAU]))
    else $error("pause bit wrong");
  a_err_latch: assert property (
    st[psr_pkg::ST_RF] |=> flt[0] ##1 (flt[0] || $past(rd_flt)))
    else $error("fault not latched");
  a_an_mask: assert property (
    ien[psr_pkg::E_AN] && ien[psr_pkg::E_GEN] && an_done_flag |=> !mgmt_irq_n)
    else $error("negotiation interrupt missing");
  a_spd_mask: assert property (
    ien[psr_pkg::E_SPD] && ien[psr_pkg::E_GEN] && speed_changed_flag
      |=> !mgmt_irq_n)
    else $error("speed interrupt missing");
  a_dup_mask: assert property (
    ien[psr_pkg::E_DUP] && ien[psr_pkg::E_GEN] && duplex_changed_flag
      |=> !mgmt_irq_n)
    else $error("duplex interrupt missing");
  a_lnk_mask: assert property (
    ien[psr_pkg::E_LNK] && ien[psr_pkg::E_GEN] && link_changed_flag
      |=> !mgmt_irq_n)
    else $error("link interrupt missing");
  a_gen_off: assert property (
    !ien[psr_pkg::E_GEN] && !ien[psr_pkg::E_TST] |=> mgmt_irq_n)
    else $error("interrupt while disabled");
  a_test_force: assert property (
    ien[psr_pkg::E_TST] |=> !mgmt_irq_n)
    else $error("test force ignored");
  a_link_flag: assert property (
    $changed(st[psr_pkg::ST_LNK]) |=> link_changed_flag [*2])
    else $error("link change lost");
  a_pend_bit: assert property (
    rd_chg |-> prdata[2] == !$past(mgmt_irq_n))
    else $error("pending bit wrong");
  a_irq_idle: assert property (
    !any_ev && !ien[psr_pkg::E_TST] |=> mgmt_irq_n)
    else $error("interrupt without cause");
  a_link_dup: assert property (
    rd_stat |-> prdata[10] == $past(st[psr_pkg::ST_LNK]) &&
      prdata[9] == $past(st[psr_pkg::ST_DUP]) &&
      prdata[15] == 1'b0 && prdata[6] == 1'b0 && prdata[2:0] == 3'h0)
    else $error("link duplex or reserved bits wrong");

  c_stat_read: cover property (rd_stat && prdata[10]);
  c_chg_clear: cover property (rd_chg && prdata[4] ##1 !link_changed_flag);
  c_irq_link: cover property (link_changed_flag && ien[4] ##1 !mgmt_irq_n);
  c_bad_addr: cover property (pslverr);
endmodule : psr_regs

// file: design/psr_sync.sv
// Purpose: Three stage synchroniser with agreement filter per bit
// Assumes: Inputs are asynchronous levels
// Notes: Output moves only when stages two and three agree
`timescale 1ns/1ps
module psr_sync #(
  parameter int WIDTH = 13
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Data
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;

  if (WIDTH < 1) begin : g_chk
    $error("psr_sync width must be positive");
  end

  // Shift chain, first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Accept a bit once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dout <= '0;
    end else begin
      dout <= (~(s2 ^ s3) & s3) | ((s2 ^ s3) & dout);
    end
  end
endmodule : psr_sync

// file: sim/psr_regs_tb_top.sv
// Purpose: Self-checking bench for the live status and enable registers
// Assumes: Zero wait APB slave, status inputs settle within 4 edges
// Notes: All register traffic goes through the APB tasks below
`timescale 1ns/1ps

`define CHK(got, exp) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
      err_total++; \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end

module psr_regs_tb_top;
  localparam logic [11:0] A_BASIC = {2'b00, psr_pkg::IDX_BASIC, 2'b00};
  localparam logic [11:0] A_STAT = {2'b00, psr_pkg::IDX_STAT, 2'b00};
  localparam logic [11:0] A_IEN = {2'b00, psr_pkg::IDX_IEN, 2'b00};
  localparam logic [11:0] A_CHG = {2'b00, psr_pkg::IDX_CHG, 2'b00};
  localparam logic [11:0] A_FLT = {2'b00, psr_pkg::IDX_FLT, 2'b00};
  logic pclk;
  logic presetn;
  logic [11:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic [3:0] pstrb;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [12:0] st;
  logic mgmt_irq_n;
  logic [31:0] rdv;
  int err_total;
  int checks_done;
  // Status bit expected for each live input, in vector order
  int bpos [10] = '{psr_pkg::B_SPD, psr_pkg::B_TX, psr_pkg::B_RX,
    psr_pkg::B_COL, psr_pkg::B_LNK, psr_pkg::B_DUP, psr_pkg::B_ANM,
    psr_pkg::B_AND, psr_pkg::B_POL, psr_pkg::B_PAU};
  // Event source, enable mask bit and change flag bit
  int esrc [4] = '{psr_pkg::ST_SPD, psr_pkg::ST_DUP, psr_pkg::ST_LNK,
    psr_pkg::ST_AND};
  int emsk [4] = '{psr_pkg::E_SPD, psr_pkg::E_DUP, psr_pkg::E_LNK,
    psr_pkg::E_AN};
  int eflg [4] = '{psr_pkg::C_SPD, psr_pkg::C_DUP, psr_pkg::C_LNK,
    psr_pkg::C_AND};

  ////////////////////////////////////////////////////////////////////////////
  // Device under test
  psr_regs u_psr_regs (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .speed_100(st[psr_pkg::ST_SPD]), .tx_active(st[psr_pkg::ST_TX]),
    .rx_active(st[psr_pkg::ST_RX]), .collision(st[psr_pkg::ST_COL]),
    .link_up(st[psr_pkg::ST_LNK]), .full_duplex(st[psr_pkg::ST_DUP]),
    .autoneg_mode(st[psr_pkg::ST_ANM]), .autoneg_done(st[psr_pkg::ST_AND]),
    .polarity_rev(st[psr_pkg::ST_POL]), .pause_capable(st[psr_pkg::ST_PAU]),
    .remote_fault(st[psr_pkg::ST_RF]), .jabber(st[psr_pkg::ST_JAB]),
    .pd_fault(st[psr_pkg::ST_PDF]), .mgmt_irq_n(mgmt_irq_n)
  );

  // Clock, 40 ns period
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic test_done;
    $display("Checks %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : test_done

  // One APB transfer, error response compared
  task automatic xfer(input logic [11:0] a, input logic w,
                      input logic [31:0] d, input logic e_err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      err_total++;
      test_done();
    end
    rdv = prdata;
    `CHK(pslverr, e_err)
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d, 1'b0);
  endtask : wr

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    xfer(a, 1'b0, 32'h0000_0000, 1'b0);
    `CHK(rdv, e)
  endtask : rd_chk

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask : idle

  // Pin sampled mid cycle, returns on a rising edge
  task automatic chk_irq(input logic e);
    @(negedge pclk);
    `CHK(mgmt_irq_n, e)
    @(posedge pclk);
  endtask : chk_irq

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    int i;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hF;
    st = 13'h0000;
    err_total = 0;
    checks_done = 0;
    idle(6);
    `CHK(mgmt_irq_n, 1'b1)
    presetn <= 1'b1;
    rd_chk(A_STAT, 32'h0000_0000);
    rd_chk(A_IEN, 32'h0000_0000);
    // Each live input alone shows only its own bit
    for (i = 0; i < 10; i++) begin
      st <= 13'h0001 << i;
      idle(8);
      rd_chk(A_STAT, 32'h1 << bpos[i]);
      if (i == psr_pkg::ST_AND) rd_chk(A_BASIC, 32'h0000_0020);
      st <= 13'h0000;
      idle(8);
    end
    // Fault sources latch the error bit until the fault register is read
    for (i = 0; i < 3; i++) begin
      st <= 13'h0001 << (psr_pkg::ST_RF + i);
      idle(8);
      st <= 13'h0000;
      idle(8);
      rd_chk(A_STAT, 32'h0000_0008);
      rd_chk(A_FLT, 32'h1 << i);
      rd_chk(A_STAT, 32'h0000_0000);
    end
    // Writable enable bits, read-only write, unmapped and misaligned
    wr(A_IEN, 32'h0000_00F3);
    rd_chk(A_IEN, 32'h0000_00F3);
    wr(A_IEN, 32'h0000_0000);
    wr(A_STAT, 32'h0000_FFFF);
    rd_chk(A_STAT, 32'h0000_0000);
    xfer(12'h050, 1'b0, 32'h0000_0000, 1'b1);
    `CHK(rdv, 32'h0000_0000)
    xfer(12'h049, 1'b1, 32'h0000_00F3, 1'b1);
    rd_chk(A_IEN, 32'h0000_0000);
    // Low byte strobe off or upper address bits set, no write lands
    pstrb <= 4'hE;
    wr(A_IEN, 32'h0000_00F3);
    pstrb <= 4'hF;
    xfer(12'h448, 1'b1, 32'h0000_00F3, 1'b1);
    rd_chk(A_IEN, 32'h0000_0000);
    // Flags left by the live input sweep, read clears them
    rd_chk(A_CHG, 32'h0000_0070);
    // Each masked event raises the pin, read clears it
    for (i = 0; i < 4; i++) begin
      wr(A_IEN, 32'h2 | (32'h1 << emsk[i]));
      st[esrc[i]] <= 1'b1;
      idle(8);
      chk_irq(1'b0);
      rd_chk(A_CHG, 32'h4 | (32'h1 << eflg[i]));
      idle(2);
      chk_irq(1'b1);
      rd_chk(A_CHG, (i == 3) ? 32'h0000_0080 : 32'h0000_0000);
    end
    // Global enable and mask both gate the pin
    wr(A_IEN, 32'h0000_00F0);
    st[psr_pkg::ST_LNK] <= 1'b0;
    idle(8);
    chk_irq(1'b1);
    wr(A_IEN, 32'h0000_0002);
    idle(2);
    chk_irq(1'b1);
    wr(A_IEN, 32'h0000_0012);
    idle(2);
    chk_irq(1'b0);
    rd_chk(A_CHG, 32'h0000_0094);
    idle(2);
    chk_irq(1'b1);
    // Test force drives the pin with no event pending
    wr(A_IEN, 32'h0000_0001);
    idle(2);
    chk_irq(1'b0);
    rd_chk(A_CHG, 32'h0000_0084);
    wr(A_IEN, 32'h0000_0000);
    idle(2);
    chk_irq(1'b1);
    test_done();
  end
endmodule : psr_regs_tb_top
